/* logic/cdcr_device.sv */
// converter end: ch3 divider register, status register, interrupt pin
// Overview of operation
// - predivide b01 divides by one, b10 by two
// - single-ended sensor: host programs predivide b10
// - reference clock is input clock over divisor; zero reserved
// - host writes zeros to reserved divider bits
// - status 15:14 names the faulting channel
// - error latched until status or channel result read
// - bit 11 records watchdog timeout since last read, only while watchdog routing is enabled
// - bit 10 records amplitude-high warning since last read
// - bit 9 records amplitude-low warning since last read
// - bit 6 flags result ready per conversion mode, set only while ready routing is enabled
// - bits 3:0 flag unread result per channel
// - ready flag routed to pin only when enabled
// - watchdog routed to pin only when enabled
// - single mode converts only the selected channel
`default_nettype none
module cdcr_device #(
    parameter int DIVISOR_W = 10
) (
    input wire logic clk,
    input wire logic rst,
    cdcr_link_if.dev link,
    input wire logic [cdcr_pkg::NUM_CH-1:0] conv_done,
    input wire logic [cdcr_pkg::NUM_CH-1:0] wd_timeout,
    input wire logic [cdcr_pkg::NUM_CH-1:0] amp_high,
    input wire logic [cdcr_pkg::NUM_CH-1:0] amp_low,
    input wire logic [cdcr_pkg::NUM_CH-1:0] active_channels,
    input wire logic sequence_mode_select,
    input wire logic [1:0] single_channel_select,
    input wire logic watchdog_irq_routing_enable,
    input wire logic ready_irq_routing_enable,
    output logic [1:0] sensor_clock_predivide,
    output logic sensor_div_by_two,
    output logic [DIVISOR_W-1:0] reference_clock_divisor,
    output logic ref_clk_en
);
    import cdcr_pkg::*;

    if (DIVISOR_W != DIV_W) begin : g_chk
        $error("divisor width must match the register field");
    end

    typedef struct packed {
        logic [15:0] div3;
        logic [1:0] chan;
        logic wd;
        logic ah;
        logic al;
        logic rdy;
        logic [NUM_CH-1:0] unread;
        logic [NUM_CH-1:0] seq_acc;
        logic [DIV_W-1:0] cnt;
        logic ref_tick;
        logic div2;
        logic ack;
        logic [15:0] rdata;
        logic irq_out;
        logic irq_oe_n;
    } cdcr_dev_state_t;

    cdcr_dev_state_t st_q;
    cdcr_dev_state_t st_d;

    logic [15:0] status_word;
    logic [DIV_W-1:0] div_val;
    logic [NUM_CH-1:0] act;
    logic [NUM_CH-1:0] rd_res;
    logic [NUM_CH-1:0] wd_v;
    logic [NUM_CH-1:0] ah_v;
    logic [NUM_CH-1:0] al_v;
    logic [NUM_CH-1:0] err_v;
    logic [NUM_CH-1:0] done_v;
    logic [NUM_CH-1:0] acc;
    logic rd_stat;
    logic clr_err;
    logic new_rdy;

    always_comb begin
        // reserved bits 13:12, 8:7, 5:4 read zero
        status_word = STATUS_RST;
        status_word[STAT_CHAN_LSB +: 2] = st_q.chan;
        status_word[STAT_WD] = st_q.wd;
        status_word[STAT_AH] = st_q.ah;
        status_word[STAT_AL] = st_q.al;
        status_word[STAT_RDY] = st_q.rdy;
        // channel 0 sits in bit 3, channel 3 in bit 0
        for (int i = 0; i < NUM_CH; i++) begin
            status_word[NUM_CH-1-i] = st_q.unread[i];
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.ack = link.req;
        st_d.ref_tick = 1'b0;
        st_d.irq_out = 1'b0;
        div_val = st_q.div3[DIV_LSB +: DIV_W];
        rd_stat = link.req && !link.we && link.addr == STATUS_OFS;
        for (int i = 0; i < NUM_CH; i++) begin
            rd_res[i] = link.req && !link.we &&
                link.addr == RESULT0_OFS + 8'(i) * RESULT_STEP;
        end

        // only the selected channel runs in single mode
        if (sequence_mode_select) begin
            act = active_channels;
        end else begin
            act = 4'b0001 << single_channel_select;
        end
        wd_v = wd_timeout & act & {NUM_CH{watchdog_irq_routing_enable}};
        ah_v = amp_high & act;
        al_v = amp_low & act;
        err_v = wd_v | ah_v | al_v;
        done_v = conv_done & act;

        // register access; predivide and reserved bits stored as written
        if (link.req && link.we && link.addr == DIV3_OFS) begin
            st_d.div3 = link.wdata;
        end
        if (link.req && !link.we) begin
            if (link.addr == STATUS_OFS) begin
                st_d.rdata = status_word;
            end else if (link.addr == DIV3_OFS) begin
                st_d.rdata = st_q.div3;
            end else begin
                st_d.rdata = 16'h0000;
            end
        end

        // clears first, then sets, so an event in the read cycle survives
        clr_err = rd_stat || |(rd_res & (4'b0001 << st_q.chan));
        if (clr_err) begin
            st_d.wd = 1'b0;
            st_d.ah = 1'b0;
            st_d.al = 1'b0;
            st_d.chan = 2'b00;
        end
        if (rd_stat) begin
            st_d.rdy = 1'b0;
        end
        st_d.unread = (st_q.unread & ~rd_res) | done_v;

        // channel field only follows a fresh error, never overwrites a held one
        if (|err_v && !(st_d.wd || st_d.ah || st_d.al)) begin
            for (int i = NUM_CH - 1; i >= 0; i--) begin
                if (err_v[i]) begin
                    st_d.chan = 2'(i);
                end
            end
        end
        st_d.wd = st_d.wd | (|wd_v);
        st_d.ah = st_d.ah | (|ah_v);
        st_d.al = st_d.al | (|al_v);

        // sequential mode waits for every active channel
        acc = st_q.seq_acc | done_v;
        new_rdy = 1'b0;
        if (!sequence_mode_select) begin
            new_rdy = |done_v;
            st_d.seq_acc = '0;
        end else if (act != '0 && (acc & act) == act) begin
            new_rdy = 1'b1;
            st_d.seq_acc = '0;
        end else begin
            st_d.seq_acc = acc;
        end
        if (new_rdy && ready_irq_routing_enable) begin
            st_d.rdy = 1'b1;
        end

        // pin low while an enabled flag is pending
        st_d.irq_oe_n = !((st_d.wd && watchdog_irq_routing_enable) ||
            (st_d.rdy && ready_irq_routing_enable));

        // a zero divisor is reserved: the reference enable then stays off
        if (div_val == '0) begin
            st_d.cnt = '0;
        end else if (st_q.cnt >= div_val - 1'b1) begin
            st_d.cnt = '0;
            st_d.ref_tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
        // b01 and unknown codes pass undivided
        st_d.div2 = st_d.div3[PREDIV_LSB +: 2] == PREDIV_BY2;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{div3: DIV3_RST, irq_oe_n: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign link.rdata = st_q.rdata;
    assign link.ack = st_q.ack;
    assign link.irq_pin_n_out = st_q.irq_out;
    assign link.irq_pin_n_oe_n = st_q.irq_oe_n;
    assign sensor_clock_predivide = st_q.div3[PREDIV_LSB +: 2];
    assign sensor_div_by_two = st_q.div2;
    assign reference_clock_divisor = st_q.div3[DIV_LSB +: DIV_W];
    assign ref_clk_en = st_q.ref_tick;
endmodule
`default_nettype wire

/* logic/cdcr_pkg.sv */
// constants shared by both ends of the converter register link
`default_nettype none
package cdcr_pkg;
    // device register map, byte offsets on the link
    localparam logic [7:0] DIV3_OFS = 8'h17;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] RESULT0_OFS = 8'h00;
    localparam logic [7:0] RESULT_STEP = 8'h02;
    localparam int NUM_CH = 4;
    // ch3_clock_dividers fields
    localparam int PREDIV_LSB = 12;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 10;
    localparam logic [1:0] PREDIV_BY1 = 2'b01;
    localparam logic [1:0] PREDIV_BY2 = 2'b10;
    localparam logic [15:0] DIV3_RST = 16'h0000;
    // converter_status fields
    localparam int STAT_CHAN_LSB = 14;
    localparam int STAT_WD = 11;
    localparam int STAT_AH = 10;
    localparam int STAT_AL = 9;
    localparam int STAT_RDY = 6;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    // controller registers on apb, byte addresses
    localparam logic [7:0] H_CMD_OFS = 8'h00;
    localparam logic [7:0] H_WDATA_OFS = 8'h04;
    localparam logic [7:0] H_RDATA_OFS = 8'h08;
    localparam logic [7:0] H_ISTAT_OFS = 8'h0c;
    localparam logic [7:0] H_IMASK_OFS = 8'h10;
    localparam logic [7:0] H_LEVEL_OFS = 8'h14;
    localparam int H_CMD_GO = 0;
    localparam int H_CMD_WE = 1;
    localparam int H_CMD_ADDR_LSB = 8;
    localparam int H_EV_DONE = 0;
    localparam int H_EV_PIN = 1;
    localparam int H_EV_W = 2;
endpackage
`default_nettype wire

/* logic/cdcr_link_if.sv */
// register link between controller and converter, with the shared interrupt wire
`default_nettype none
interface cdcr_link_if (
    input wire logic clk,
    input wire logic rst
);
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    logic irq_pin_n_out;
    logic irq_pin_n_oe_n;
    logic irq_pin_n_level;
    // open drain with pull-up: low only while the device drives it
    assign irq_pin_n_level = irq_pin_n_oe_n ? 1'b1 : irq_pin_n_out;
    modport dev (
        input req, we, addr, wdata,
        output rdata, ack, irq_pin_n_out, irq_pin_n_oe_n
    );
    modport host (
        output req, we, addr, wdata,
        input rdata, ack, irq_pin_n_level
    );
endinterface
`default_nettype wire

/* logic/cdcr_host.sv */
// controller end: apb registers driving the converter link
`default_nettype none
module cdcr_host (
    input wire logic clk,
    input wire logic rst,
    cdcr_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import cdcr_pkg::*;

    typedef enum {HS_IDLE, HS_WAIT} cdcr_hstate_t;

    typedef struct packed {
        cdcr_hstate_t fsm;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [H_EV_W-1:0] istat;
        logic [H_EV_W-1:0] imask;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } cdcr_host_state_t;

    cdcr_host_state_t hs_q;
    cdcr_host_state_t hs_d;
    logic setup;
    logic wr;
    logic [H_EV_W-1:0] ev;
    logic [7:0] a;

    always_comb begin
        hs_d = hs_q;
        hs_d.req = 1'b0;
        hs_d.pready = 1'b0;
        ev = '0;
        a = paddr[7:0];
        setup = psel && !penable;
        wr = psel && penable && hs_q.pready && pwrite;

        // no wait state: answer registered in the setup cycle
        if (setup) begin
            hs_d.pready = 1'b1;
            hs_d.pslverr = 1'b0;
            hs_d.prdata = 32'h0000_0000;
            if (paddr[31:8] != '0 || paddr[1:0] != 2'b00) begin
                hs_d.pslverr = 1'b1;
            end else if (a == H_CMD_OFS) begin
                hs_d.prdata[H_CMD_ADDR_LSB +: 8] = hs_q.addr;
                hs_d.prdata[H_CMD_WE] = hs_q.we;
            end else if (a == H_WDATA_OFS) begin
                hs_d.prdata[15:0] = hs_q.wdata;
            end else if (a == H_RDATA_OFS) begin
                hs_d.prdata[15:0] = hs_q.rdata;
            end else if (a == H_ISTAT_OFS) begin
                hs_d.prdata[H_EV_W-1:0] = hs_q.istat;
            end else if (a == H_IMASK_OFS) begin
                hs_d.prdata[H_EV_W-1:0] = hs_q.imask;
            end else if (a == H_LEVEL_OFS) begin
                hs_d.prdata[0] = hs_q.fsm == HS_WAIT;
                hs_d.prdata[1] = hs_q.pin_s2;
            end else begin
                hs_d.pslverr = 1'b1;
            end
        end

        if (wr && !hs_q.pslverr) begin
            if (a == H_CMD_OFS) begin
                // a go while a transfer is open is dropped
                if (pwdata[H_CMD_GO] && hs_q.fsm == HS_IDLE) begin
                    hs_d.req = 1'b1;
                    hs_d.fsm = HS_WAIT;
                    hs_d.we = pwdata[H_CMD_WE];
                    hs_d.addr = pwdata[H_CMD_ADDR_LSB +: 8];
                end
            end else if (a == H_WDATA_OFS) begin
                // software keeps reserved divider bits zero through this word
                hs_d.wdata = pwdata[15:0];
            end else if (a == H_ISTAT_OFS) begin
                hs_d.istat = hs_q.istat & ~pwdata[H_EV_W-1:0];
            end else if (a == H_IMASK_OFS) begin
                hs_d.imask = pwdata[H_EV_W-1:0];
            end
        end

        if (hs_q.fsm == HS_WAIT && link.ack) begin
            hs_d.fsm = HS_IDLE;
            ev[H_EV_DONE] = 1'b1;
            if (!hs_q.we) begin
                hs_d.rdata = link.rdata;
            end
        end

        // pin comes from the other chip: two flops before any use
        hs_d.pin_s1 = link.irq_pin_n_level;
        hs_d.pin_s2 = hs_q.pin_s1;
        hs_d.pin_prev = hs_q.pin_s2;
        ev[H_EV_PIN] = hs_q.pin_prev && !hs_q.pin_s2;

        // set wins over a same-cycle write-one clear
        hs_d.istat = hs_d.istat | ev;
        hs_d.irq = |(hs_d.istat & hs_d.imask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_q <= '{fsm: HS_IDLE, pin_s1: 1'b1, pin_s2: 1'b1, pin_prev: 1'b1, default: '0};
        end else begin
            hs_q <= hs_d;
        end
    end

    assign link.req = hs_q.req;
    assign link.we = hs_q.we;
    assign link.addr = hs_q.addr;
    assign link.wdata = hs_q.wdata;
    assign prdata = hs_q.prdata;
    assign pready = hs_q.pready;
    assign pslverr = hs_q.pslverr;
    assign irq = hs_q.irq;
endmodule
`default_nettype wire

/* verification/cdcr_link_assertions.sv */
// link-side assertions for the converter register link
`default_nettype none
module cdcr_link_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic irq_pin_n_out,
    input wire logic irq_pin_n_oe_n
);
    import cdcr_pkg::*;
    logic [15:0] div_q;
    logic rd_q;
    logic [7:0] ra_q;
    // shadow of the divider word, so a read-back can be judged without the design
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= DIV3_RST;
            rd_q <= 1'b0;
            ra_q <= 8'h00;
        end else begin
            if (req && we && addr == DIV3_OFS)
                div_q <= wdata;
            rd_q <= req && !we;
            ra_q <= addr;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_ack_next: assert property (req |=> ack)
        else $error("ack missing after request");
    chk_ack_stray: assert property (!req |=> !ack)
        else $error("ack without request");
    chk_status_reserved: assert property (ack && rd_q && ra_q == STATUS_OFS |->
        rdata[13:12] == 2'b00 && rdata[8:7] == 2'b00 && rdata[5:4] == 2'b00)
        else $error("reserved status bits not zero");
    chk_div_readback: assert property (ack && rd_q && ra_q == DIV3_OFS |-> rdata == div_q)
        else $error("divider read-back differs from last write");
    chk_other_zero: assert property (ack && rd_q && ra_q != DIV3_OFS && ra_q != STATUS_OFS
        |-> rdata == 16'h0000)
        else $error("result or unmapped read not zero");
    chk_rdata_held: assert property ($changed(rdata) |-> ack && rd_q)
        else $error("read data moved outside a read answer");
    chk_pin_reset: assert property ($past(rst) |-> irq_pin_n_oe_n)
        else $error("pin driven right after reset");
    chk_pin_low: assert property (!irq_pin_n_oe_n |-> !irq_pin_n_out)
        else $error("pin driven to a high level");
endmodule
`default_nettype wire

/* verification/status_and_ch3_divider_regs_tb.sv */
// self-checking bench joining controller and converter ends over the link
`default_nettype none
module status_and_ch3_divider_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cdcr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, irq, e, pd2, ref_en;
    logic [3:0] done = 4'h0, wd = 4'h0, ah = 4'h0, al = 4'h0, act = 4'h0;
    logic seq = 1'b0, wd_en = 1'b0, rdy_en = 1'b0;
    logic [1:0] sel = 2'b00;
    logic [1:0] pd;
    logic [9:0] dv;
    logic [15:0] v;
    int fails = 0, samples_checked = 0, gap = 0, last_gap = 0, pulses = 0, n;
    wire logic pin;
    always #5 clk = ~clk;
    cdcr_link_if link_inst (.clk(clk), .rst(rst));
    assign pin = link_inst.irq_pin_n_level;
    cdcr_device #(.DIVISOR_W(10)) cdcr_device_inst (.clk(clk), .rst(rst), .link(link_inst.dev),
        .conv_done(done), .wd_timeout(wd), .amp_high(ah), .amp_low(al), .active_channels(act),
        .sequence_mode_select(seq), .single_channel_select(sel),
        .watchdog_irq_routing_enable(wd_en), .ready_irq_routing_enable(rdy_en),
        .sensor_clock_predivide(pd), .sensor_div_by_two(pd2), .reference_clock_divisor(dv),
        .ref_clk_en(ref_en));
    cdcr_host cdcr_host_inst (.clk(clk), .rst(rst), .link(link_inst.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    cdcr_link_assertions cdcr_link_assertions_inst (.clk(clk), .rst(rst),
        .req(link_inst.req), .we(link_inst.we), .addr(link_inst.addr),
        .wdata(link_inst.wdata), .rdata(link_inst.rdata), .ack(link_inst.ack),
        .irq_pin_n_out(link_inst.irq_pin_n_out), .irq_pin_n_oe_n(link_inst.irq_pin_n_oe_n));
    // spacing of reference enables, counted edge to edge
    always @(posedge clk) begin
        gap <= ref_en ? 1 : gap + 1;
        if (ref_en)
            last_gap <= gap;
        pulses <= pulses + int'(ref_en);
    end
    function automatic logic [15:0] sx(logic [1:0] c, logic [2:0] f, logic y, logic [3:0] u);
        return {c, 2'b00, f, 2'b00, y, 2'b00, u};
    endfunction
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no answer time assumed: only the watchdog ends a lost answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one link access through the controller; r ends holding the read data
    task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, H_WDATA_OFS, {16'h0, d});
        apb(1'b1, H_CMD_OFS, {16'h0, a, 6'h0, w, 1'b1});
        // a transfer that never finishes is left to the watchdog
        do begin
            apb(1'b0, H_ISTAT_OFS, 32'h0);
        end while (r[H_EV_DONE] !== 1'b1);
        apb(1'b1, H_ISTAT_OFS, 32'h1);
        apb(1'b0, H_RDATA_OFS, 32'h0);
    endtask
    // one-cycle event: 0 done, 1 watchdog, 2 amplitude high, 3 amplitude low
    task automatic ev(input int k, input logic [3:0] m);
        @(posedge clk);
        case (k)
            0: done <= m;
            1: wd <= m;
            2: ah <= m;
            default: al <= m;
        endcase
        @(posedge clk);
        {done, wd, ah, al} <= 16'h0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        void'($urandom(32'h20c7d398));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        dev(1'b0, STATUS_OFS, 16'h0);
        check("status_reset", r, 32'h0);
        for (int i = 0; i < 6; i++) begin
            v = {2'b00, 2'(i % 4), 2'b00, (i == 5) ? 10'h0 : 10'($urandom_range(1, 9))};
            dev(1'b1, DIV3_OFS, v);
            dev(1'b0, DIV3_OFS, 16'h0);
            check("div_readback", r, {16'h0, v});
            check("predivide", pd, v[13:12]);
            check("div_by_two", pd2, v[13:12] == PREDIV_BY2);
            check("divisor", dv, v[9:0]);
            n = pulses;
            repeat (30) @(posedge clk);
            if (v[9:0] == 10'h0)
                check("ref_idle", pulses - n, 0);
            else
                check("ref_period", last_gap, v[9:0]);
        end
        dev(1'b1, STATUS_OFS, 16'hffff);
        dev(1'b0, STATUS_OFS, 16'h0);
        check("status_ro", r, 32'h0);
        wd_en <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            sel <= 2'(c);
            ev(1, 4'(1 << c));
            check("pin_wd", pin, 1'b0);
            dev(1'b0, STATUS_OFS, 16'h0);
            check("status_wd", r, sx(2'(c), 3'b100, 1'b0, 4'h0));
            check("pin_release", pin, 1'b1);
            ev(2, 4'(1 << c));
            ev(3, 4'(1 << c));
            check("pin_amp", pin, 1'b1);
            dev(1'b0, STATUS_OFS, 16'h0);
            check("status_amp", r, sx(2'(c), 3'b011, 1'b0, 4'h0));
            dev(1'b0, STATUS_OFS, 16'h0);
            check("status_clear", r, 32'h0);
        end
        sel <= 2'd2;
        ev(1, 4'b0100);
        dev(1'b0, RESULT0_OFS, 16'h0);
        check("latch_other", pin, 1'b0);
        dev(1'b0, RESULT0_OFS + 2 * RESULT_STEP, 16'h0);
        check("latch_result", pin, 1'b1);
        dev(1'b0, STATUS_OFS, 16'h0);
        check("err_result", r[11:9], 3'b000);
        ev(1, 4'($urandom_range(0, 3) == 2 ? 4'b0001 : 4'b0010));
        check("inactive", pin, 1'b1);
        wd_en <= 1'b0;
        ev(1, 4'b0100);
        dev(1'b0, STATUS_OFS, 16'h0);
        check("wd_gated", r, 32'h0);
        check("wd_gated_pin", pin, 1'b1);
        sel <= 2'd0;
        ev(0, 4'b0001);
        dev(1'b0, STATUS_OFS, 16'h0);
        check("rdy_gated", r, sx(2'b00, 3'b000, 1'b0, 4'b1000));
        rdy_en <= 1'b1;
        ev(0, 4'b0001);
        check("pin_rdy", pin, 1'b0);
        dev(1'b0, STATUS_OFS, 16'h0);
        check("rdy_single", r, sx(2'b00, 3'b000, 1'b1, 4'b1000));
        dev(1'b0, RESULT0_OFS, 16'h0);
        dev(1'b0, STATUS_OFS, 16'h0);
        check("unread_clear", r, 32'h0);
        check("unread_clear_pin", pin, 1'b1);
        seq <= 1'b1;
        act <= 4'b0101;
        ev(0, 4'b0001);
        dev(1'b0, STATUS_OFS, 16'h0);
        check("seq_partial", r[13:0], 14'h0008);
        ev(0, 4'b0100);
        dev(1'b0, STATUS_OFS, 16'h0);
        check("seq_all", r[13:0], 14'h004a);
        apb(1'b0, H_ISTAT_OFS, 32'h0);
        check("pin_event", {irq, r[H_EV_PIN]}, 2'b01);
        apb(1'b1, H_IMASK_OFS, 32'h2);
        // irq is launched at the edge that ends the write: look one edge later
        @(posedge clk);
        check("irq_raise", irq, 1'b1);
        apb(1'b1, H_ISTAT_OFS, 32'h2);
        @(posedge clk);
        check("irq_clear", irq, 1'b0);
        apb(1'b0, H_IMASK_OFS, 32'h0);
        check("imask_readback", r, 32'h2);
        apb(1'b0, H_LEVEL_OFS, 32'h0);
        check("level_idle", r, 32'h2);
        apb(1'b0, 8'h02, 32'h0);
        check("misaligned", e, 1'b1);
        apb(1'b0, 8'h44, 32'h0);
        check("unmapped", e, 1'b1);
        end_of_test();
    end
    // whole run is about a thousand cycles; this only cuts a hang short
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
